// File: design/occ_channel_ctrl.sv
// Output channel configuration and reference sequencing behind an AXI4-Lite slave
`timescale 1ns/1ns
module occ_channel_ctrl import occ_pkg::*; #(
  parameter int ADDR_W = 8
) (
  // Clock, reset, enable
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic clk_en,
  // AXI4-Lite write
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Reference event sources
  input wire logic sysref_ext_trig,
  input wire logic sysref_pulse,
  // Output control
  output occ_out_s clk_out_cfg [OCC_NUM_CLK],
  output occ_out_s ref_out_cfg [OCC_NUM_REF],
  output logic [OCC_NUM_REF-1:0] ref_div_shared,
  output logic [OCC_NUM_REF-1:0] ref_delay_own,
  output logic sysref_run
);

  // Stored register index of a byte offset
  function automatic logic [3:0] reg_idx(input logic [7:0] ofs);
    reg_idx = ofs[5:2];
  endfunction : reg_idx

  // Used by both read and write paths to decide SLVERR
  function automatic logic is_mapped(input logic [ADDR_W-1:0] addr);
    is_mapped = (addr[1:0] == 2'h0) && (addr[ADDR_W-1:2] <= ADDR_W'(OCC_OFS_STATUS >> 2));
  endfunction : is_mapped

  function automatic logic [2:0] chan_of(input logic [29:0] map, input int i);
    chan_of = map[3*i +: 3];
  endfunction : chan_of

  // Register file
  logic [31:0] cfg [OCC_NREG];
  logic [31:0] next_cfg [OCC_NREG];

  wire logic [4:0] chan_pd = cfg[reg_idx(OCC_OFS_CHAN_PD)][4:0];
  wire logic [9:0] clk_pd = cfg[reg_idx(OCC_OFS_CLK_PD)][9:0];
  wire logic [9:0] clk_permit = cfg[reg_idx(OCC_OFS_CLK_PERMIT)][9:0];
  wire logic [19:0] clk_swing = cfg[reg_idx(OCC_OFS_CLK_SWING)][19:0];
  wire logic [7:0] ref_func = cfg[reg_idx(OCC_OFS_REF_FUNC)][7:0];
  wire logic [7:0] ref_pd = cfg[reg_idx(OCC_OFS_REF_PD)][7:0];
  wire logic [7:0] ref_permit = cfg[reg_idx(OCC_OFS_REF_PERMIT)][7:0];
  wire logic [15:0] ref_swing = cfg[reg_idx(OCC_OFS_REF_SWING)][15:0];
  wire logic [7:0] ref_hold = cfg[reg_idx(OCC_OFS_REF_HOLD)][7:0];
  wire logic [31:0] seq_ctrl = cfg[reg_idx(OCC_OFS_SEQ_CTRL)];
  wire logic [7:0] burst_len = seq_ctrl[OCC_SEQ_LEN_LSB +: 8];
  wire logic cont_mode = seq_ctrl[OCC_SEQ_CONT_BIT];
  wire logic ext_en = seq_ctrl[OCC_SEQ_EXT_BIT];
  // A zero burst length would never end; it runs as a single pulse
  wire logic [7:0] eff_len = (burst_len == 8'h00) ? 8'h01 : burst_len;

  // AXI state
  logic aw_held, w_held;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic next_aw_held, next_w_held, next_awready, next_wready;
  logic [ADDR_W-1:0] next_aw_addr;
  logic [31:0] next_w_data;
  logic [3:0] next_w_strb;
  logic next_bvalid, next_arready, next_rvalid;
  logic [1:0] next_bresp, next_rresp;
  logic [31:0] next_rdata;
  logic start_cmd, stop_cmd;

  // Sequencer state
  occ_seq_e seq_state, next_seq_state;
  logic [7:0] pulse_cnt, next_pulse_cnt;
  logic next_sysref_run;
  logic [OCC_NUM_REF-1:0] next_ref_div_shared, next_ref_delay_own;

  // External trigger synchroniser and settled level
  logic [2:0] trig_sync;
  logic trig_level, next_trig_level;
  logic trig_edge;

  always_comb begin
    logic do_write;
    logic [3:0] widx;
    do_write = 1'b0;
    widx = 4'h0;
    next_aw_held = aw_held;
    next_aw_addr = aw_addr;
    next_w_held = w_held;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = s_axi_bvalid;
    next_bresp = s_axi_bresp;
    next_cfg = cfg;
    start_cmd = 1'b0;
    stop_cmd = 1'b0;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    // Both halves are held before the write takes effect; one response at a time
    if (aw_held && w_held && !s_axi_bvalid) begin
      do_write = 1'b1;
      widx = aw_addr[5:2];
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = is_mapped(aw_addr) ? OCC_RESP_OKAY : OCC_RESP_SLVERR;
    end
    if (do_write && is_mapped(aw_addr)) begin
      if (int'(widx) < OCC_NREG) begin
        for (int b = 0; b < 4; b++) begin
          if (w_strb[b]) begin
            next_cfg[widx][8*b +: 8] = w_data[8*b +: 8] & OCC_WMASK[widx][8*b +: 8];
          end
        end
      end else if (widx == reg_idx(OCC_OFS_SEQ_CMD) && w_strb[0]) begin
        start_cmd = w_data[OCC_CMD_START_BIT];
        stop_cmd = w_data[OCC_CMD_STOP_BIT];
      end
    end
    next_awready = !next_aw_held;
    next_wready = !next_w_held;
  end

  always_comb begin
    logic [3:0] ridx;
    ridx = s_axi_araddr[5:2];
    next_arready = s_axi_arready;
    next_rvalid = s_axi_rvalid;
    next_rdata = s_axi_rdata;
    next_rresp = s_axi_rresp;
    if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
      next_arready = 1'b1;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_arready = 1'b0;
      next_rvalid = 1'b1;
      next_rdata = 32'h00000000;
      next_rresp = OCC_RESP_OKAY;
      if (!is_mapped(s_axi_araddr)) begin
        next_rresp = OCC_RESP_SLVERR;
      end else if (int'(ridx) < OCC_NREG) begin
        next_rdata = cfg[ridx];
      end else if (ridx == reg_idx(OCC_OFS_STATUS)) begin
        next_rdata[OCC_STAT_ACTIVE_BIT] = (seq_state == OCC_SEQ_RUN);
        next_rdata[OCC_STAT_CNT_LSB +: 8] = pulse_cnt;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      cfg <= OCC_RST;
      aw_held <= 1'b0;
      aw_addr <= '0;
      w_held <= 1'b0;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= OCC_RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= OCC_RESP_OKAY;
    end else if (clk_en) begin
      cfg <= next_cfg;
      aw_held <= next_aw_held;
      aw_addr <= next_aw_addr;
      w_held <= next_w_held;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      s_axi_awready <= next_awready;
      s_axi_wready <= next_wready;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
      // Ready rises one cycle after reset so no address is taken mid-reset
      s_axi_arready <= next_arready | (!s_axi_arready && !s_axi_rvalid);
      s_axi_rvalid <= next_rvalid;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
    end
  end

  // Trigger pin: a new level counts only once stages two and three agree
  always_comb begin
    next_trig_level = (trig_sync[1] == trig_sync[2]) ? trig_sync[2] : trig_level;
    trig_edge = next_trig_level && !trig_level;
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      trig_sync <= 3'h0;
      trig_level <= 1'b0;
    end else if (clk_en) begin
      trig_sync <= {trig_sync[1:0], sysref_ext_trig};
      trig_level <= next_trig_level;
    end
  end

  // Reference event sequencer
  always_comb begin
    next_seq_state = seq_state;
    next_pulse_cnt = pulse_cnt;
    unique case (seq_state)
      OCC_SEQ_IDLE: begin
        if (start_cmd || (ext_en && trig_edge)) begin
          next_seq_state = OCC_SEQ_RUN;
          next_pulse_cnt = 8'h00;
        end
      end
      OCC_SEQ_RUN: begin
        if (stop_cmd) begin
          next_seq_state = OCC_SEQ_IDLE;
        end else if (sysref_pulse && !cont_mode) begin
          next_pulse_cnt = pulse_cnt + 8'h01;
          if (next_pulse_cnt >= eff_len) begin
            next_seq_state = OCC_SEQ_IDLE;
          end
        end
      end
    endcase
    next_sysref_run = (next_seq_state == OCC_SEQ_RUN);
    next_ref_div_shared = ref_func;
    next_ref_delay_own = ref_func;
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      seq_state <= OCC_SEQ_IDLE;
      pulse_cnt <= 8'h00;
      sysref_run <= 1'b0;
      ref_div_shared <= '0;
      ref_delay_own <= '0;
    end else if (clk_en) begin
      seq_state <= next_seq_state;
      pulse_cnt <= next_pulse_cnt;
      sysref_run <= next_sysref_run;
      ref_div_shared <= next_ref_div_shared;
      ref_delay_own <= next_ref_delay_own;
    end
  end

  // Clock outputs: channel and own power-down, own permit and swing; E has no reference
  for (genvar i = 0; i < OCC_NUM_CLK; i++) begin : g_clk
    occ_out_ctrl u_out (
      .sys_clk(sys_clk),
      .srst(srst),
      .clk_en(clk_en),
      .power_down(chan_pd[chan_of(OCC_CLK_CHAN, i)] | clk_pd[i]),
      .drive_permit(clk_permit[i]),
      .swing_select(clk_swing[2*i +: 2]),
      .ref_function(1'b0),
      .seq_active(1'b0),
      .idle_hold(1'b0),
      .out_cfg(clk_out_cfg[i])
    );
  end

  // Reference outputs in reference function ignore their own power-down bit
  for (genvar r = 0; r < OCC_NUM_REF; r++) begin : g_ref
    occ_out_ctrl u_out (
      .sys_clk(sys_clk),
      .srst(srst),
      .clk_en(clk_en),
      .power_down(chan_pd[chan_of({6'h00, OCC_REF_CHAN}, r)] | (ref_pd[r] & !ref_func[r])),
      .drive_permit(ref_permit[r]),
      .swing_select(ref_swing[2*r +: 2]),
      .ref_function(ref_func[r]),
      .seq_active(seq_state == OCC_SEQ_RUN),
      .idle_hold(ref_hold[r]),
      .out_cfg(ref_out_cfg[r])
    );
  end

  property p_burst_end;
    @(posedge sys_clk) disable iff (srst)
      (clk_en && seq_state == OCC_SEQ_RUN && !cont_mode && !stop_cmd && sysref_pulse
       && (pulse_cnt + 8'h01) == eff_len) |=> (seq_state == OCC_SEQ_IDLE && !sysref_run);
  endproperty
  a_burst_end: assert property (p_burst_end) else $error("burst did not end on count");

  property p_cont_holds;
    @(posedge sys_clk) disable iff (srst)
      (clk_en && seq_state == OCC_SEQ_RUN && cont_mode && !stop_cmd)
      |=> (seq_state == OCC_SEQ_RUN);
  endproperty
  a_cont_holds: assert property (p_cont_holds) else $error("continuous event stopped");

  property p_ref_on;
    @(posedge sys_clk) disable iff (srst)
      (clk_en && seq_state == OCC_SEQ_IDLE && start_cmd)
      |=> (seq_state == OCC_SEQ_RUN && sysref_run);
  endproperty
  a_ref_on: assert property (p_ref_on) else $error("event did not start on command");

  property p_route;
    @(posedge sys_clk) disable iff (srst)
      clk_en |=> (ref_div_shared == $past(ref_func) && ref_delay_own == $past(ref_func));
  endproperty
  a_route: assert property (p_route) else $error("divider or delay routing wrong");

endmodule : occ_channel_ctrl

// File: design/occ_pkg.sv
// Constants and types for the output channel and reference control block
package occ_pkg;

  // Output counts: clocks A0 A1 A2 B0 B1 C0 C1 D E0 E1, references A0..D
  localparam int OCC_NUM_CHAN = 5;
  localparam int OCC_NUM_CLK = 10;
  localparam int OCC_NUM_REF = 8;
  // Channel index of each clock and each reference output, three bits each
  localparam logic [29:0] OCC_CLK_CHAN = 30'h24691200;
  localparam logic [23:0] OCC_REF_CHAN = 24'h691200;

  // Register byte offsets
  localparam logic [7:0] OCC_OFS_CHAN_PD = 8'h00;
  localparam logic [7:0] OCC_OFS_CLK_PD = 8'h04;
  localparam logic [7:0] OCC_OFS_CLK_PERMIT = 8'h08;
  localparam logic [7:0] OCC_OFS_CLK_SWING = 8'h0C;
  localparam logic [7:0] OCC_OFS_REF_FUNC = 8'h10;
  localparam logic [7:0] OCC_OFS_REF_PD = 8'h14;
  localparam logic [7:0] OCC_OFS_REF_PERMIT = 8'h18;
  localparam logic [7:0] OCC_OFS_REF_SWING = 8'h1C;
  localparam logic [7:0] OCC_OFS_REF_HOLD = 8'h20;
  localparam logic [7:0] OCC_OFS_SEQ_CTRL = 8'h24;
  localparam logic [7:0] OCC_OFS_SEQ_CMD = 8'h28;
  localparam logic [7:0] OCC_OFS_STATUS = 8'h2C;
  localparam int OCC_NREG = 10;

  // Writable bits and reset values of the stored registers, by index
  localparam logic [31:0] OCC_WMASK [OCC_NREG] = '{
    32'h0000001F, 32'h000003FF, 32'h000003FF, 32'h000FFFFF, 32'h000000FF,
    32'h000000FF, 32'h000000FF, 32'h0000FFFF, 32'h000000FF, 32'h000003FF};
  localparam logic [31:0] OCC_RST [OCC_NREG] = '{
    32'h0000001F, 32'h00000000, 32'h00000000, 32'h00055555, 32'h00000000,
    32'h00000000, 32'h00000000, 32'h00005555, 32'h00000000, 32'h00000001};

  // Field positions
  localparam int OCC_SEQ_LEN_LSB = 0;
  localparam int OCC_SEQ_CONT_BIT = 8;
  localparam int OCC_SEQ_EXT_BIT = 9;
  localparam int OCC_CMD_START_BIT = 0;
  localparam int OCC_CMD_STOP_BIT = 1;
  localparam int OCC_STAT_ACTIVE_BIT = 0;
  localparam int OCC_STAT_CNT_LSB = 8;

  // Bus responses
  localparam logic [1:0] OCC_RESP_OKAY = 2'h0;
  localparam logic [1:0] OCC_RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {OCC_OFF, OCC_LOW, OCC_ON, OCC_MID} occ_drive_e;
  typedef enum logic {OCC_SEQ_IDLE, OCC_SEQ_RUN} occ_seq_e;

  // Resolved state of one output; swing is 00 unless the output drives
  typedef struct packed {
    occ_drive_e drive;
    logic [1:0] swing;
  } occ_out_s;

endpackage : occ_pkg

// File: design/occ_out_ctrl.sv
// Resolves the drive state of one clock or reference output
`timescale 1ns/1ns
module occ_out_ctrl import occ_pkg::*; (
  // Clock, reset, enable
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic clk_en,
  // Settings
  input wire logic power_down,
  input wire logic drive_permit,
  input wire logic [1:0] swing_select,
  input wire logic ref_function,
  input wire logic seq_active,
  input wire logic idle_hold,
  // Resolved state
  output occ_out_s out_cfg
);

  occ_out_s next_out_cfg;

  always_comb begin
    next_out_cfg.drive = OCC_OFF;
    next_out_cfg.swing = 2'h0;
    if (power_down) begin
      next_out_cfg.drive = OCC_OFF;
    end else if (ref_function && !seq_active) begin
      next_out_cfg.drive = idle_hold ? OCC_MID : OCC_OFF;
    end else if (!drive_permit) begin
      next_out_cfg.drive = OCC_LOW;
    end else begin
      next_out_cfg.drive = OCC_ON;
      next_out_cfg.swing = swing_select;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      out_cfg <= '{drive: OCC_OFF, swing: 2'h0};
    end else if (clk_en) begin
      out_cfg <= next_out_cfg;
    end
  end

  property p_pd_off;
    @(posedge sys_clk) disable iff (srst)
      (clk_en && power_down) |=> (out_cfg.drive == OCC_OFF && out_cfg.swing == 2'h0);
  endproperty
  a_pd_off: assert property (p_pd_off) else $error("powered-down output not off");

  property p_permit_low;
    @(posedge sys_clk) disable iff (srst)
      (clk_en && !power_down && !drive_permit && (!ref_function || seq_active))
      |=> (out_cfg.drive == OCC_LOW && out_cfg.swing == 2'h0);
  endproperty
  a_permit_low: assert property (p_permit_low) else $error("unpermitted output not low");

  property p_swing;
    @(posedge sys_clk) disable iff (srst)
      (clk_en && !power_down && drive_permit && (!ref_function || seq_active))
      |=> (out_cfg.drive == OCC_ON && out_cfg.swing == $past(swing_select));
  endproperty
  a_swing: assert property (p_swing) else $error("enabled output swing wrong");

  property p_idle_hold;
    @(posedge sys_clk) disable iff (srst)
      (clk_en && !power_down && ref_function && !seq_active)
      |=> (out_cfg.drive == ($past(idle_hold) ? OCC_MID : OCC_OFF));
  endproperty
  a_idle_hold: assert property (p_idle_hold) else $error("idle reference state wrong");

endmodule : occ_out_ctrl

// File: test/occ_conv_model.sv
// Far-side model: reference pulse source for the sequencer and converter-side pulse counter
`timescale 1ns/1ns
module occ_conv_model #(
  parameter int PERIOD = 4
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // Reference link
  input wire logic sysref_run,
  output logic sysref_pulse,
  output logic [15:0] pulse_cnt
);
  localparam logic [7:0] LAST = 8'(PERIOD - 1);
  logic [7:0] div;

  // Only pulses issued while the run flag is high reach the converters
  always @(posedge sys_clk) begin
    if (srst) begin
      div <= 8'h00;
      sysref_pulse <= 1'b0;
      pulse_cnt <= 16'h0000;
    end else begin
      sysref_pulse <= sysref_run && (div == LAST);
      div <= (sysref_run && div != LAST) ? div + 8'h01 : 8'h00;
      if (sysref_pulse && sysref_run) begin
        pulse_cnt <= pulse_cnt + 16'h0001;
      end
    end
  end
endmodule : occ_conv_model

// File: test/tb_output_channel_sysref_control.sv
// Self-checking bench for the output channel and reference control block
`timescale 1ns/1ns
module tb_output_channel_sysref_control import occ_pkg::*; ;
  logic sys_clk;
  logic srst;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic awvalid, wvalid, arvalid, trig;
  logic awready, wready, bvalid, arready, rvalid, run, pulse;
  logic [1:0] bresp, rresp;
  occ_out_s clk_cfg [OCC_NUM_CLK];
  occ_out_s ref_cfg [OCC_NUM_REF];
  logic [7:0] div_sh, dly_own;
  logic [15:0] pcnt, p0;
  int error_cnt, tests_run;
  // Shadow of the stored registers, by index
  logic [31:0] sh [OCC_NREG];
  logic exp_run;
  logic ce;
  logic [3:0] strb;

  occ_channel_ctrl #(.ADDR_W(8)) DUT (
    .sys_clk(sys_clk), .srst(srst), .clk_en(ce),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(strb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1),
    .sysref_ext_trig(trig), .sysref_pulse(pulse),
    .clk_out_cfg(clk_cfg), .ref_out_cfg(ref_cfg),
    .ref_div_shared(div_sh), .ref_delay_own(dly_own), .sysref_run(run)
  );

  occ_conv_model #(.PERIOD(4)) PEER (
    .sys_clk(sys_clk), .srst(srst), .sysref_run(run),
    .sysref_pulse(pulse), .pulse_cnt(pcnt)
  );

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic test_done();
    $display("checks=%0d errors=%0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : test_done

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Address and data are offered together and each is dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    logic ad, wd;
    n = 0;
    ad = 1'b0;
    wd = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    forever begin
      @(posedge sys_clk);
      n++;
      if (n > 200) error_cnt++;
      if ((ad && wd && bvalid) || n > 200) break;
      if (awready) begin
        ad = 1'b1;
        awvalid <= 1'b0;
      end
      if (wready) begin
        wd = 1'b1;
        wvalid <= 1'b0;
      end
    end
    chk({30'h0, bresp}, {30'h0, er});
    if (er == OCC_RESP_OKAY && a[7:2] < OCC_NREG) sh[a[7:2]] = d & OCC_WMASK[a[7:2]];
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    logic ad;
    n = 0;
    ad = 1'b0;
    araddr <= a;
    arvalid <= 1'b1;
    forever begin
      @(posedge sys_clk);
      n++;
      if (n > 200) error_cnt++;
      if ((ad && rvalid) || n > 200) break;
      if (arready) begin
        ad = 1'b1;
        arvalid <= 1'b0;
      end
    end
    chk(rdata, ed);
    chk({30'h0, rresp}, {30'h0, er});
  endtask : rd

  function automatic occ_out_s ex(input logic pd, input logic pm, input logic [1:0] sw);
    ex.drive = pd ? OCC_OFF : (pm ? OCC_ON : OCC_LOW);
    ex.swing = (!pd && pm) ? sw : 2'h0;
  endfunction : ex

  task automatic chk_outs();
    occ_out_s e;
    logic [2:0] ch;
    for (int i = 0; i < OCC_NUM_CLK; i++) begin
      ch = OCC_CLK_CHAN[3*i+:3];
      e = ex(sh[0][ch] | sh[1][i], sh[2][i], sh[3][2*i+:2]);
      chk({28'h0, clk_cfg[i]}, {28'h0, e});
    end
    for (int r = 0; r < OCC_NUM_REF; r++) begin
      ch = OCC_REF_CHAN[3*r+:3];
      e = ex(sh[0][ch] | (sh[5][r] & ~sh[4][r]), sh[6][r], sh[7][2*r+:2]);
      if (sh[4][r] && (sh[0][ch] || !exp_run)) begin
        e.drive = (sh[8][r] && !sh[0][ch]) ? OCC_MID : OCC_OFF;
        e.swing = 2'h0;
      end
      chk({28'h0, ref_cfg[r]}, {28'h0, e});
    end
    chk({24'h0, div_sh}, {24'h0, sh[4][7:0]});
    chk({24'h0, dly_own}, {24'h0, sh[4][7:0]});
  endtask : chk_outs

  task automatic wait_run(input logic lvl);
    int n;
    n = 0;
    while (run !== lvl && n < 3000) begin
      @(posedge sys_clk);
      n++;
    end
    chk({31'h0, run}, {31'h0, lvl});
    exp_run = lvl;
    // Output states follow the run flag one edge later
    repeat (2) @(posedge sys_clk);
    chk_outs();
  endtask : wait_run

  task automatic start_event(input logic [31:0] ctrl, input logic ext);
    wr(OCC_OFS_SEQ_CTRL, ctrl, OCC_RESP_OKAY);
    p0 = pcnt;
    if (ext) trig <= 1'b1;
    else wr(OCC_OFS_SEQ_CMD, 32'h1, OCC_RESP_OKAY);
    wait_run(1'b1);
    trig <= 1'b0;
  endtask : start_event

  initial begin
    repeat (20000) @(posedge sys_clk);
    error_cnt++;
    test_done();
  end

  initial begin
    srst = 1'b1;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    awvalid = 1'b0;
    wvalid = 1'b0;
    arvalid = 1'b0;
    trig = 1'b0;
    ce = 1'b1;
    strb = 4'hF;
    exp_run = 1'b0;
    error_cnt = 0;
    tests_run = 0;
    for (int k = 0; k < OCC_NREG; k++) sh[k] = OCC_RST[k];
    repeat (3) @(posedge sys_clk);
    srst <= 1'b0;
    @(posedge sys_clk);
    chk_outs();
    for (int k = 0; k < OCC_NREG; k++) begin
      rd(8'(4 * k), OCC_RST[k], OCC_RESP_OKAY);
      wr(8'(4 * k), 32'hFFFFFFFF, OCC_RESP_OKAY);
      rd(8'(4 * k), OCC_WMASK[k], OCC_RESP_OKAY);
      wr(8'(4 * k), OCC_RST[k], OCC_RESP_OKAY);
    end
    wr(8'h30, 32'h1, OCC_RESP_SLVERR);
    wr(8'h05, 32'h1, OCC_RESP_SLVERR);
    rd(8'h31, 32'h0, OCC_RESP_SLVERR);
    wr(OCC_OFS_STATUS, 32'hFFFFFFFF, OCC_RESP_OKAY);
    rd(OCC_OFS_STATUS, 32'h0, OCC_RESP_OKAY);
    rd(OCC_OFS_SEQ_CMD, 32'h0, OCC_RESP_OKAY);
    // Only byte lane 0 may change
    strb <= 4'h1;
    wr(OCC_OFS_CLK_SWING, 32'hFFFFFFFF, OCC_RESP_OKAY);
    strb <= 4'hF;
    rd(OCC_OFS_CLK_SWING, 32'h000555FF, OCC_RESP_OKAY);
    wr(OCC_OFS_CLK_SWING, OCC_RST[3], OCC_RESP_OKAY);
    wr(OCC_OFS_CHAN_PD, 32'h0, OCC_RESP_OKAY);
    wr(OCC_OFS_CLK_PD, 32'h8, OCC_RESP_OKAY);
    wr(OCC_OFS_CLK_PERMIT, 32'h3DF, OCC_RESP_OKAY);
    wr(OCC_OFS_CLK_SWING, 32'hE4E4E, OCC_RESP_OKAY);
    wr(OCC_OFS_REF_FUNC, 32'h0F, OCC_RESP_OKAY);
    wr(OCC_OFS_REF_PD, 32'h31, OCC_RESP_OKAY);
    wr(OCC_OFS_REF_PERMIT, 32'hBE, OCC_RESP_OKAY);
    // Reference-function outputs keep the 500 mV code
    wr(OCC_OFS_REF_SWING, 32'hE455, OCC_RESP_OKAY);
    // Midpoint hold only on the AC-coupled differential output
    wr(OCC_OFS_REF_HOLD, 32'h02, OCC_RESP_OKAY);
    repeat (3) @(posedge sys_clk);
    chk_outs();
    wr(OCC_OFS_CHAN_PD, 32'h11, OCC_RESP_OKAY);
    repeat (3) @(posedge sys_clk);
    chk_outs();
    // A2 off with channel A, D on with code 01, independent of the index table
    chk({24'h0, clk_cfg[2], clk_cfg[7]}, 32'h00000009);
    wr(OCC_OFS_CHAN_PD, 32'h0, OCC_RESP_OKAY);
    start_event(32'h0FF, 1'b0);
    wait_run(1'b0);
    chk({16'h0, pcnt - p0}, 32'd255);
    start_event(32'h201, 1'b1);
    wait_run(1'b0);
    chk({16'h0, pcnt - p0}, 32'd1);
    // Frozen sequencer ignores pulses, so a two-pulse burst outlives them
    start_event(32'h002, 1'b0);
    ce <= 1'b0;
    repeat (40) @(posedge sys_clk);
    chk({31'h0, run}, 32'h1);
    chk_outs();
    ce <= 1'b1;
    wait_run(1'b0);
    start_event(32'h100, 1'b0);
    repeat (300) @(posedge sys_clk);
    chk({31'h0, run}, 32'h1);
    rd(OCC_OFS_STATUS, 32'h1, OCC_RESP_OKAY);
    wr(OCC_OFS_SEQ_CMD, 32'h2, OCC_RESP_OKAY);
    wait_run(1'b0);
    test_done();
  end
endmodule : tb_output_channel_sysref_control
